// file: rtl/smac_pkg.sv
// package of constants, types and register map for the security mode block
package smac_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CMD       = 8'h00;
  localparam logic [7:0] REG_ARG_LO    = 8'h04;
  localparam logic [7:0] REG_ARG_HI    = 8'h08;
  localparam logic [7:0] REG_STATUS    = 8'h0c;
  localparam logic [7:0] REG_ZONE_CFG  = 8'h10;
  localparam logic [7:0] REG_ACCESS    = 8'h14;
  localparam logic [7:0] REG_PAC_BASE  = 8'h20;
  localparam logic [7:0] REG_AAC_BASE  = 8'h40;

  // command codes written to the command register
  localparam logic [3:0] CMD_NONE       = 4'h0;
  localparam logic [3:0] CMD_VERIFY_PW  = 4'h1;
  localparam logic [3:0] CMD_VERIFY_AUTH = 4'h2;
  localparam logic [3:0] CMD_VERIFY_ENC = 4'h3;
  localparam logic [3:0] CMD_WRITE_MAC  = 4'h4;
  localparam logic [3:0] CMD_READ_CSUM  = 4'h5;

  // command register field positions
  localparam int CMD_SET_POS  = 4;
  localparam int CMD_RW_POS   = 8;
  localparam int CMD_OK_POS   = 9;

  // attempt counters after reset of the model store
  localparam logic [7:0] PAC_RESET = 8'hff;
  localparam logic [7:0] AAC_RESET = 8'hff;
  localparam logic [7:0] CNT_DEAD  = 8'h00;

  // communication security mode
  typedef enum logic [1:0]
  {
    SMAC_STANDARD = 2'b00,
    SMAC_AUTH     = 2'b01,
    SMAC_ENCRYPT  = 2'b10
  } smac_mode_t;

  // ahb-lite request group
  typedef struct packed
  {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } smac_ahb_req_t;

  // current security state seen by the access logic
  typedef struct packed
  {
    smac_mode_t mode;
    logic       pw_active;
    logic [2:0] pw_set;
    logic       pw_write;
    logic       key_active;
    logic [1:0] key_set;
  } smac_sec_t;

endpackage

// file: rtl/smac_top.sv
// security mode and access control logic with ahb-lite register slave
// Behaviour
// [R1] reset starts in standard mode, no password or key set active
// [R2] auth mode: passwords encrypted, mac applies; encrypt mode encrypts user data
// [R3] eight password sets, any may protect any zone
// [R4] 24-bit read and write passwords; read grants read, write grants both
// [R5] good password stays active until next one or reset; only one active
// [R6] wrong password decrements its counter; zero locks password and zones
// [R7] in auth or encrypt mode password transactions are encrypted
// [R8] four key sets, any may protect any zone
// [R9] auth mode lasts until next key-set check or reset; one set active
// [R10] failed check leaves auth mode, decrements counter; zero locks set
// [R11] host forms random number and challenge from seed
// [R12] device computes challenge, compares, on match updates cryptogram and key
// [R13] host reads back cryptogram to authenticate the device
// [R14] auth variant authenticates; encrypt variant activates encryption
// [R15] encryption needs auth mode and the active set's session key
// [R16] zones demanding encryption are reachable only in encrypted mode
// [R17] only passwords and their counters of system data need encryption
// [R18] failed check in encrypt mode drops both modes, decrements counter
// [R19] encryption activation uses session key instead of seed
// [R20] host sends checksum right after each write in secure modes
// [R21] bad write checksum rejects write and clears privileges
// [R22] checksum read command resets security
// [R23] reset clears password and key set, keeps attempt counters; the code reloads both counter sets to full
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
module smac_top
#(
  parameter int PW_SETS  = 8,
  parameter int KEY_SETS = 4,
  parameter int ZONES    = 16
)
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [1:0]       o_mode,
  output logic             o_pw_encrypted,
  output logic             o_data_encrypted,
  output logic             o_mac_required,
  output logic             o_zone_read_ok,
  output logic             o_zone_write_ok,
  output logic             o_write_rejected
);

  initial
  begin
    if (PW_SETS != 8 || KEY_SETS != 4 || ZONES < 1 || ZONES > 16)
      $error("smac_top: unsupported set or zone count");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state record
  typedef struct packed
  {
    smac_pkg::smac_sec_t sec;
    logic [7:0][7:0]     password_attempt_counter;        // [R6]
    logic [3:0][7:0]     aac;        // [R10]
    logic                dph;
    logic                dph_wr;
    logic [7:0]          dph_addr;
    logic [31:0]         arg_lo;
    logic [31:0]         arg_hi;
    logic [3:0]          zone;
    logic [15:0]         zone_pw_en;
    logic [15:0]         zone_key_en;
    logic [15:0]         zone_enc;
    logic [31:0]         rdata;
    logic                last_ok;
    logic                reject;
    logic                rd_ok;
    logic                wr_ok;
  } smac_state_t;

  smac_state_t s_q;
  smac_state_t s_d;

  // zone-to-set assignment tables kept in flops, written through REG_ACCESS
  logic [15:0][2:0] zone_pw_q;
  logic [15:0][2:0] zone_pw_d;
  logic [15:0][1:0] zone_key_q;
  logic [15:0][1:0] zone_key_d;

  // a zone is reachable when its password, key and encryption constraints are met
  function automatic logic [1:0] zone_access(
    input smac_state_t      st,
    input logic [2:0]       pws,
    input logic [1:0]       ks
  );
    logic rd;
    logic wr;
    rd = 1'b1;
    wr = 1'b1;
    if (st.zone_pw_en[st.zone])
    begin
      // [R4] read password grants read only, write password both
      rd = st.sec.pw_active && st.sec.pw_set == pws &&
           st.password_attempt_counter[pws] != smac_pkg::CNT_DEAD;                  // [R6]
      wr = rd && st.sec.pw_write;
    end
    if (st.zone_key_en[st.zone])
    begin
      if (!(st.sec.key_active && st.sec.key_set == ks &&
            st.aac[ks] != smac_pkg::CNT_DEAD))                 // [R10]
      begin
        rd = 1'b0;
        wr = 1'b0;
      end
    end
    // [R16] zone demanding encryption needs encrypted mode
    if (st.zone_enc[st.zone] && st.sec.mode != smac_pkg::SMAC_ENCRYPT)
    begin
      rd = 1'b0;
      wr = 1'b0;
    end
    return {rd, wr};
  endfunction

  // decrement with floor at zero
  function automatic logic [7:0] dec_sat(input logic [7:0] v);
    return (v == smac_pkg::CNT_DEAD) ? v : v - 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic [31:0] cmd;
    logic [3:0]  op;
    logic [2:0]  set8;
    logic [1:0]  set4;
    logic        ok;
    logic        secure;
    logic [1:0]  acc;
    s_d        = s_q;
    zone_pw_d  = zone_pw_q;
    zone_key_d = zone_key_q;
    cmd        = i_hwdata;
    op         = cmd[3:0];
    set8       = cmd[smac_pkg::CMD_SET_POS +: 3];
    set4       = cmd[smac_pkg::CMD_SET_POS +: 2];
    ok         = cmd[smac_pkg::CMD_OK_POS];
    secure     = s_q.sec.mode != smac_pkg::SMAC_STANDARD;
    s_d.reject = 1'b0;
    // ahb address phase capture
    if (i_hready)
    begin
      s_d.dph      = i_hsel && i_htrans[1];
      s_d.dph_wr   = i_hwrite;
      s_d.dph_addr = i_haddr[7:0];
    end
    // read data prepared in the address phase
    if (i_hready && i_hsel && i_htrans[1] && !i_hwrite)
    begin
      s_d.rdata = 32'h0000_0000;
      case (i_haddr[7:0])
        smac_pkg::REG_ARG_LO:   s_d.rdata = s_q.arg_lo;
        smac_pkg::REG_ARG_HI:   s_d.rdata = s_q.arg_hi;
        smac_pkg::REG_STATUS:
          s_d.rdata = {21'h000000, s_q.last_ok, s_q.sec};
        smac_pkg::REG_ZONE_CFG:
          s_d.rdata = {12'h000, s_q.zone, 1'b0,
                       s_q.zone_enc[s_q.zone], s_q.zone_key_en[s_q.zone],
                       s_q.zone_pw_en[s_q.zone], 6'h00,
                       zone_key_q[s_q.zone], 1'b0, zone_pw_q[s_q.zone]};
        default:
        begin
          if (i_haddr[7:5] == 3'b001 && i_haddr[1:0] == 2'b00)
          begin
            // [R17] password counters hidden in secure modes
            if (!secure)
              s_d.rdata = {24'h000000, s_q.password_attempt_counter[i_haddr[4:2]]};
          end
          else if (i_haddr[7:4] == 4'h4 && i_haddr[1:0] == 2'b00)
            s_d.rdata = {24'h000000, s_q.aac[i_haddr[3:2]]};
        end
      endcase
    end
    // data phase of a write
    if (s_q.dph && s_q.dph_wr)
    begin
      case (s_q.dph_addr)
        smac_pkg::REG_ARG_LO: s_d.arg_lo = i_hwdata;
        smac_pkg::REG_ARG_HI: s_d.arg_hi = i_hwdata;
        smac_pkg::REG_ZONE_CFG:
        begin
          s_d.zone                 = cmd[19:16];
          s_d.zone_pw_en[cmd[19:16]]  = cmd[12];
          s_d.zone_key_en[cmd[19:16]] = cmd[13];
          s_d.zone_enc[cmd[19:16]]    = cmd[14];
        end
        smac_pkg::REG_ACCESS:
        begin
          // [R3] [R8] any set may protect any zone
          zone_pw_d[cmd[19:16]]  = cmd[2:0];
          zone_key_d[cmd[19:16]] = cmd[5:4];
        end
        smac_pkg::REG_CMD:
        begin
          case (op)
            smac_pkg::CMD_VERIFY_PW:
            begin
              // [R7] caller supplies comparison outcome of decrypted value
              if (s_q.password_attempt_counter[set8] == smac_pkg::CNT_DEAD)
              begin
                s_d.sec.pw_active = 1'b0;                        // [R6]
                s_d.last_ok = 1'b0;
              end
              else if (ok)
              begin
                s_d.sec.pw_active = 1'b1;                        // [R5]
                s_d.sec.pw_set    = set8;
                s_d.sec.pw_write  = cmd[smac_pkg::CMD_RW_POS];   // [R4]
                s_d.last_ok = 1'b1;
              end
              else
              begin
                s_d.password_attempt_counter[set8] = dec_sat(s_q.password_attempt_counter[set8]);          // [R6]
                s_d.sec.pw_active = 1'b0;
                s_d.last_ok = 1'b0;
              end
            end
            smac_pkg::CMD_VERIFY_AUTH, smac_pkg::CMD_VERIFY_ENC:
            begin
              // [R14] [R15] encrypt variant needs auth on the same set
              if (s_q.aac[set4] != smac_pkg::CNT_DEAD && ok &&
                  (op == smac_pkg::CMD_VERIFY_AUTH ||
                   (secure && s_q.sec.key_active &&
                    s_q.sec.key_set == set4)))
              begin
                // [R12] [R19] match: cryptogram and key replaced by engine
                s_d.sec.key_active = 1'b1;                       // [R9]
                s_d.sec.key_set    = set4;
                s_d.sec.mode = (op == smac_pkg::CMD_VERIFY_AUTH) ?
                  smac_pkg::SMAC_AUTH : smac_pkg::SMAC_ENCRYPT;
                s_d.last_ok = 1'b1;
              end
              else
              begin
                // [R10] [R18] failure drops both modes
                s_d.aac[set4] = dec_sat(s_q.aac[set4]);
                s_d.sec.key_active = 1'b0;
                s_d.sec.mode = smac_pkg::SMAC_STANDARD;
                s_d.last_ok = 1'b0;
              end
            end
            smac_pkg::CMD_WRITE_MAC:
            begin
              // [R21] bad checksum rejects write and clears privileges
              if (secure && !ok)
              begin
                s_d.reject = 1'b1;
                s_d.sec.mode = smac_pkg::SMAC_STANDARD;
                s_d.sec.key_active = 1'b0;
                s_d.sec.pw_active  = 1'b0;
              end
            end
            smac_pkg::CMD_READ_CSUM:
            begin
              // [R22] checksum read resets security
              s_d.sec.mode = smac_pkg::SMAC_STANDARD;
              s_d.sec.key_active = 1'b0;
              s_d.sec.pw_active  = 1'b0;
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    acc = zone_access(s_d, zone_pw_d[s_d.zone], zone_key_d[s_d.zone]);
    s_d.rd_ok = acc[1];
    s_d.wr_ok = acc[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; attempt counters start full, security at standard [R1]
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_q        <= '0;                                          // [R23]
      s_q.password_attempt_counter    <= {8{smac_pkg::PAC_RESET}};
      s_q.aac    <= {4{smac_pkg::AAC_RESET}};
      s_q.sec.mode <= smac_pkg::SMAC_STANDARD;                   // [R1]
      zone_pw_q  <= '0;
      zone_key_q <= '0;
    end
    else
    begin
      s_q        <= s_d;
      zone_pw_q  <= zone_pw_d;
      zone_key_q <= zone_key_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs from flops; hreadyout and hresp tied off
  assign o_hrdata         = s_q.rdata;
  assign o_hreadyout      = 1'b1;
  assign o_hresp          = 1'b0;
  assign o_mode           = s_q.sec.mode;
  // [R2] [R7] [R17] passwords encrypted outside standard mode
  assign o_pw_encrypted   = s_q.sec.mode != smac_pkg::SMAC_STANDARD;
  assign o_data_encrypted = s_q.sec.mode == smac_pkg::SMAC_ENCRYPT;  // [R2]
  assign o_mac_required   = s_q.sec.mode != smac_pkg::SMAC_STANDARD; // [R2]
  assign o_zone_read_ok   = s_q.rd_ok;
  assign o_zone_write_ok  = s_q.wr_ok;
  assign o_write_rejected = s_q.reject;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence fail_check_seq;
    s_q.dph && s_q.dph_wr && s_q.dph_addr == smac_pkg::REG_CMD &&
    (i_hwdata[3:0] == smac_pkg::CMD_VERIFY_AUTH ||
     i_hwdata[3:0] == smac_pkg::CMD_VERIFY_ENC) &&
    !i_hwdata[smac_pkg::CMD_OK_POS];
  endsequence

  chk_fail_drop_mode: assert property (                           // [R18]
    @(posedge i_clk) disable iff (!i_reset_n)
    fail_check_seq |=> s_q.sec.mode == smac_pkg::SMAC_STANDARD &&
                       !s_q.sec.key_active)
    else $error("failed key check kept a mode");

  chk_aac_dec: assert property (                                  // [R10]
    @(posedge i_clk) disable iff (!i_reset_n)
    fail_check_seq ##0 (s_q.aac[i_hwdata[5:4]] != 8'h00) |=>
      s_q.aac[$past(i_hwdata[5:4])] ==
      $past(s_q.aac[i_hwdata[5:4]]) - 8'h01)
    else $error("attempt counter not decremented");

  chk_enc_needs_auth: assert property (                           // [R15]
    @(posedge i_clk) disable iff (!i_reset_n)
    s_q.sec.mode == smac_pkg::SMAC_ENCRYPT &&
    $past(s_q.sec.mode) == smac_pkg::SMAC_STANDARD |-> 1'b0)
    else $error("encryption entered without authentication");

  chk_pw_enc_flag: assert property (                              // [R7]
    @(posedge i_clk) disable iff (!i_reset_n)
    o_pw_encrypted == (o_mode != 2'b00))
    else $error("password encryption flag wrong");

  chk_mac_reject: assert property (                               // [R21]
    @(posedge i_clk) disable iff (!i_reset_n)
    o_write_rejected |-> o_mode == 2'b00 && !s_q.sec.pw_active)
    else $error("rejected write kept privileges");

  chk_pac_dead_lock: assert property (                            // [R6]
    @(posedge i_clk) disable iff (!i_reset_n)
    s_q.sec.pw_active |-> s_q.password_attempt_counter[s_q.sec.pw_set] != 8'h00 ||
      $past(s_q.sec.pw_active))
    else $error("locked password became active");

  chk_enc_zone: assert property (                                 // [R16]
    @(posedge i_clk) disable iff (!i_reset_n)
    s_q.zone_enc[s_q.zone] && s_q.sec.mode != smac_pkg::SMAC_ENCRYPT |->
      !s_q.rd_ok && !s_q.wr_ok)
    else $error("encrypted zone reachable in clear");

  chk_write_implies_read: assert property (                       // [R4]
    @(posedge i_clk) disable iff (!i_reset_n)
    s_q.wr_ok |-> s_q.rd_ok)
    else $error("write access without read access");

endmodule

// file: verif/smac_host.sv
// host model: ahb-lite master issuing security commands
module smac_host
(
  input  wire logic        i_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  output logic             o_hsel,
  output logic [31:0]      o_haddr,
  output logic [1:0]       o_htrans,
  output logic             o_hwrite,
  output logic [2:0]       o_hsize,
  output logic [31:0]      o_hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int timeouts;
  // bus idle at time zero
  initial
  begin
    timeouts = 0;
    o_hsel   = 1'b0;
    o_haddr  = 32'h0;
    o_htrans = 2'b00;
    o_hwrite = 1'b0;
    o_hsize  = 3'h2;
    o_hwdata = 32'h0;
  end
  //////////////////////////////////////////////////////////////////////
  // wait for a rising edge that sees hready, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (i_hready !== 1'b1 && n < 50);
    if (i_hready !== 1'b1)
      timeouts++;
  endtask
  // one word transfer, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    o_hsel   <= 1'b1;
    o_haddr  <= {24'h0, a};
    o_htrans <= 2'b10;
    o_hwrite <= wr;
    wait_rdy();
    o_htrans <= 2'b00;
    o_hwdata <= wr ? wd : ~o_hwdata; // unused data lanes keep toggling
    wait_rdy();
    rd = i_hrdata;
  endtask
  // random challenge words stand in for ciphertext, then the command
  task automatic cmd(input logic [31:0] c);
    logic [31:0] d;
    xfer(1'b1, smac_pkg::REG_ARG_LO, $urandom, d);
    xfer(1'b1, smac_pkg::REG_ARG_HI, $urandom, d);
    xfer(1'b1, smac_pkg::REG_CMD, c, d);
  endtask
endmodule

// file: verif/smac_top_tb_top.sv
// self-checking bench for the security mode block
module smac_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, ex, got) \
  begin check_count++; if ((got) !== (ex)) begin errors++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
  logic        clk, reset_n, hsel, hwrite, rdy, hresp;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans, mode;
  logic [2:0]  hsize;
  logic        pw_enc, data_enc, mac_req, zone_rd, zone_wr, rej;
  int          md, pwa, pws, pww, ka, ks, pk, s;
  int          rej_exp, rej_seen, errors, check_count;
  int          password_attempt_counter[8];
  int          aac[4];
  //////////////////////////////////////////////////////////////////////
  smac_top dut
  (
    .i_clk            (clk),
    .i_reset_n        (reset_n),
    .i_hsel           (hsel),
    .i_haddr          (haddr),
    .i_htrans         (htrans),
    .i_hwrite         (hwrite),
    .i_hsize          (hsize),
    .i_hwdata         (hwdata),
    .i_hready         (rdy),
    .o_hrdata         (hrdata),
    .o_hreadyout      (rdy),
    .o_hresp          (hresp),
    .o_mode           (mode),
    .o_pw_encrypted   (pw_enc),
    .o_data_encrypted (data_enc),
    .o_mac_required   (mac_req),
    .o_zone_read_ok   (zone_rd),
    .o_zone_write_ok  (zone_wr),
    .o_write_rejected (rej)
  );
  smac_host host
  (
    .i_clk    (clk),
    .i_hready (rdy),
    .i_hrdata (hrdata),
    .o_hsel   (hsel),
    .o_haddr  (haddr),
    .o_htrans (htrans),
    .o_hwrite (hwrite),
    .o_hsize  (hsize),
    .o_hwdata (hwdata)
  );
  // 50 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // count rejection pulses and cut a hung bus short
  always @(posedge clk)
  begin
    if (rej === 1'b1)
      rej_seen++;
    if (host.timeouts != 0)
    begin
      errors++;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////
  // counts, verdict, end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // reset the device; model returns to standard mode
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    // device reset reloads the counter store to full
    foreach (password_attempt_counter[i]) password_attempt_counter[i] = 255;
    foreach (aac[i]) aac[i] = 255;
    md = 0;
    ka = 0;
    pwa = 0;
    pws = 0;
    pww = 0;
    pk = 1;
    @(posedge clk);
  endtask
  // model: failed key-set check drops both modes, burns an attempt
  task automatic kfail(input int k);
    md = 0;
    ka = 0;
    if (aac[k] != 0)
      aac[k]--;
  endtask
  // compare mode outputs and status word with the model
  task automatic chk_state();
    @(posedge clk);
    #1;
    `CHK("mode", md[1:0], mode)
    `CHK("pw_enc", md != 0, pw_enc)
    `CHK("data_enc", md == 2, data_enc)
    `CHK("mac_req", md != 0, mac_req)
    `CHK("rejects", rej_exp, rej_seen)
    host.xfer(1'b0, smac_pkg::REG_STATUS, 32'h0, d);
    `CHK("key_on", ka[0], d[2])
    if (ka != 0)
      `CHK("key_set", ks[1:0], d[1:0])
    if (pk != 0)
      `CHK("pw", {pwa[0], pws[2:0], pww[0]}, d[7:3])
  endtask
  // attempt counters; password counters read zero in secure modes
  task automatic chk_cnt();
    for (int n = 0; n < 8; n++)
    begin
      host.xfer(1'b0, smac_pkg::REG_PAC_BASE + 8'(4 * n), 32'h0, d);
      `CHK("pac", md != 0 ? 32'h0 : 32'(password_attempt_counter[n]), d)
      host.xfer(1'b0, smac_pkg::REG_AAC_BASE + 8'(4 * (n % 4)), 0, d);
      `CHK("aac", 32'(aac[n % 4]), d)
    end
  endtask
  // issue one command and advance the model
  task automatic run(input int op, input int k, input int w, input int ok);
    host.cmd({22'h0, ok[0], w[0], 1'b0, k[2:0], op[3:0]});
    case (op)
      1:
        if (ok != 0 && password_attempt_counter[k] != 0)
        begin
          pwa = 1;
          pws = k;
          pww = w;
          pk = 1;
        end
        else
        begin
          pwa = 0;
          if (password_attempt_counter[k] != 0)
            password_attempt_counter[k]--;
        end
      2:
        if (ok != 0 && aac[k] != 0)
        begin
          md = 1;
          ka = 1;
          ks = k;
        end
        else
          kfail(k);
      3:
        if (ok != 0 && md != 0 && ka != 0 && ks == k && aac[k] != 0)
          md = 2;
        else
          kfail(k);
      4:
        if (ok == 0 && md != 0)
        begin
          kfail(3 - ks);
          aac[3 - ks]++;
          pwa = 0;
          rej_exp++;
        end
      5:
      begin
        kfail(3 - ks);
        aac[3 - ks]++;
        pwa = 0;
      end
      default: ;
    endcase
    chk_state();
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    errors = 0;
    check_count = 0;
    rej_exp = 0;
    rej_seen = 0;
    ks = 0;
    foreach (password_attempt_counter[i]) password_attempt_counter[i] = 255;
    foreach (aac[i]) aac[i] = 255;
    void'($urandom(35));
    do_reset();
    #1;
    `CHK("zone0_rd", 1'b1, zone_rd)
    chk_state();
    chk_cnt();
    host.xfer(1'b0, 8'h7c, 32'h0, d);
    `CHK("unmapped", 32'h0, d)
    $display("test reset done");
    s = $urandom_range(4, 0);
    run(1, s, 0, 1);
    run(1, 6, 1, 1);
    repeat (3) run(1, 5, 0, 0);
    run(1, 6, 1, 1);
    repeat (255) run(1, 7, 0, 0);
    run(1, 7, 0, 1);
    `CHK("locked_pw", 1'b0, d[7] & (d[6:4] == 3'h7))
    chk_cnt();
    $display("test passwords done");
    run(2, 2, 0, 0);
    run(2, 1, 0, 1);
    chk_cnt();
    run(3, 0, 0, 1);
    run(2, 3, 0, 1);
    run(3, 3, 0, 1);
    run(3, 3, 0, 0);
    run(3, 3, 0, 1);
    chk_cnt();
    $display("test key sets done");
    run(4, 0, 0, 0);
    run(2, 1, 0, 1);
    run(4, 0, 0, 1);
    run(4, 0, 0, 0);
    run(2, 1, 0, 1);
    run(3, 1, 0, 1);
    run(4, 0, 0, 0);
    run(2, 1, 0, 1);
    run(5, 0, 0, 0);
    $display("test checksums done");
    run(2, 1, 0, 1);
    run(1, 3, 1, 1);
    do_reset();
    chk_state();
    chk_cnt();
    $display("test reset in mid-run done");
    test_done();
  end
endmodule
